// File: core/flash_ctrl_consts.vh
// constants for the flash program/erase controller
`ifndef FLASH_CTRL_CONSTS_VH
`define FLASH_CTRL_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define IDX_COMMAND      12'hFF8
`define IDX_PAGE         12'hFF9
`define IDX_KHZ_HIGH     12'hFFA
`define IDX_KHZ_LOW      12'hFFB
`define IDX_DEBUG_CTRL   12'hFFC
`define IDX_ACCESS       12'hFFD

// command codes
`define CMD_UNLOCK1      8'h73
`define CMD_UNLOCK2      8'h8C
`define CMD_PAGE_ERASE   8'h95
`define CMD_MASS_ERASE   8'h63
`define CMD_PROT_SELECT  8'h5E

// state field codes
`define ST_LOCKED        6'h00
`define ST_FIRST         6'h01
`define ST_SECOND        6'h02
`define ST_UNLOCKED      6'h03
`define ST_PROT_SEL      6'h04
`define ST_PROGRAM       6'h08
`define ST_PAGE_ERASE    6'h10
`define ST_MASS_ERASE    6'h20

// field positions and reset values
`define INFO_BIT         7
`define PAGE_MSB         6
`define RESET_BYTE       8'h00

// operation times: program in microseconds, erases in milliseconds
`define PROGRAM_US       16'h0028
`define PAGE_ERASE_MS    16'h000A
`define MASS_ERASE_MS    16'h00C8

// flash boundaries: user area ends below 8 KB, reserved region is 8 KB..12 KB
`define USER_TOP         16'h2000
`define RESERVED_TOP     16'h3000
`define INFO_BASE        16'hFE00
`endif

// File: core/op_timer.v
// timer that counts kHz-scaled ticks to time one program or erase
`include "flash_ctrl_consts.vh"

module op_timer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        start_i,
    input  wire        millis_i,
    input  wire [15:0] units_i,
    input  wire [15:0] khz_i,
    output reg         busy_o,
    output reg         done_o
);

    // ----------------------------------------
    // tick divider
    // ----------------------------------------
    // a millisecond is khz clocks and a microsecond khz/1000 clocks
    reg [15:0]  sub_q;
    reg [15:0]  units_q;
    reg         millis_q;
    wire [15:0] ms_limit  = (khz_i == 16'h0000) ? 16'h0001 : khz_i;
    wire [15:0] us_clocks = khz_i / 16'h03E8;
    // below 1 MHz a microsecond rounds up to one clock, so programs run long
    wire [15:0] us_limit  = (us_clocks == 16'h0000) ? 16'h0001 : us_clocks;
    wire        ms_tick   = (sub_q >= ms_limit - 16'h0001);
    wire        us_tick   = (sub_q >= us_limit - 16'h0001);
    wire        unit_tick = millis_q ? ms_tick : us_tick;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sub_q    <= 16'h0000;
            units_q  <= 16'h0000;
            millis_q <= 1'b0;
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o   <= 1'b1;
                millis_q <= millis_i;
                units_q  <= (units_i == 16'h0000) ? 16'h0001 : units_i;
                sub_q    <= 16'h0000;
            end else if (busy_o) begin
                sub_q <= unit_tick ? 16'h0000 : sub_q + 16'h0001;
                if (unit_tick) begin
                    if (units_q == 16'h0001) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                    units_q <= units_q - 16'h0001;
                end
            end
        end
    end
endmodule

// File: core/flash_ctrl.v
// flash program/erase controller with wishbone register slave
//
// The Wishbone register port was chosen for this implementation.
`include "flash_ctrl_consts.vh"

module flash_ctrl (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [13:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        write_protect_i,
    input  wire        prog_req_i,
    input  wire [15:0] prog_addr_i,
    input  wire        exec_reserved_i,
    output reg         prog_go_o,
    output reg         page_erase_go_o,
    output reg         mass_erase_go_o,
    output reg  [6:0]  erase_page_o,
    output reg         cpu_stall_o,
    output reg         info_map_o,
    output reg         access_ok_o
);

    // ----------------------------------------
    // state codes
    // ----------------------------------------
    // one code per unlock step, one for protect select, three more for the running operations
    localparam [2:0] S_LOCKED   = 3'd0;
    localparam [2:0] S_FIRST    = 3'd1;
    localparam [2:0] S_SECOND   = 3'd2;
    localparam [2:0] S_UNLOCKED = 3'd3;
    localparam [2:0] S_PROT     = 3'd4;
    localparam [2:0] S_PROGRAM  = 3'd5;
    localparam [2:0] S_PERASE   = 3'd6;
    localparam [2:0] S_MERASE   = 3'd7;

    reg [2:0]  state_q;
    reg [7:0]  page_q;
    reg [7:0]  prot_q;
    reg [7:0]  khz_high_q;
    reg [7:0]  khz_low_q;
    reg        debug_mode_q;
    reg        page_open_q;
    reg        wrote_byte_q;
    reg        timer_start_q;
    reg        timer_millis_q;
    reg [15:0] timer_units_q;

    wire        timer_busy;
    wire        timer_done;
    wire [15:0] khz_value = {khz_high_q, khz_low_q};

    op_timer u_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (timer_start_q),
        .millis_i (timer_millis_q),
        .units_i  (timer_units_q),
        .khz_i    (khz_value),
        .busy_o   (timer_busy),
        .done_o   (timer_done)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        req     = cyc_i && stb_i && !ack_o;
    wire [11:0] idx     = adr_i[13:2];
    // writes lacking byte lane 0 are acked but change nothing
    wire        lane0   = sel_i[0];
    wire        wr      = req && we_i && lane0;
    wire [7:0]  wbyte   = dat_i[7:0];
    wire        wr_cmd  = wr && (idx == `IDX_COMMAND);
    wire        wr_page = wr && (idx == `IDX_PAGE);
    wire        wr_dbg  = wr && (idx == `IDX_DEBUG_CTRL);
    wire        busy    = (state_q == S_PROGRAM) || (state_q == S_PERASE) ||
                          (state_q == S_MERASE);

    // ----------------------------------------
    // protection checks
    // ----------------------------------------
    // sector of a page is its top three page bits
    wire [2:0] page_sector  = page_q[`PAGE_MSB:4];
    wire [2:0] addr_sector  = prog_addr_i[15:13];
    wire       page_locked  = prot_q[page_sector];
    wire       addr_locked  = prot_q[addr_sector];
    // debugger bypasses option protect and sector bits alike
    wire       wp_block     = write_protect_i && !debug_mode_q;
    wire       erase_ok     = !wp_block && (debug_mode_q || !page_locked);
    wire       in_page      = (prog_addr_i[15:9] == page_q[`PAGE_MSB:0]);
    wire       prog_ok      = !wp_block && (debug_mode_q || (in_page && !addr_locked));

    // state field, upper two bits forced clear
    reg [5:0] state_code;
    always @* begin
        case (state_q)
            S_LOCKED:   state_code = `ST_LOCKED;
            S_FIRST:    state_code = `ST_FIRST;
            S_SECOND:   state_code = `ST_SECOND;
            S_UNLOCKED: state_code = `ST_UNLOCKED;
            S_PROT:     state_code = `ST_PROT_SEL;
            S_PROGRAM:  state_code = `ST_PROGRAM;
            S_PERASE:   state_code = `ST_PAGE_ERASE;
            default:    state_code = `ST_MASS_ERASE;
        endcase
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    reg [7:0] rbyte;
    always @* begin
        if (idx == `IDX_COMMAND) begin
            rbyte = {2'b00, state_code};
        end else if (idx == `IDX_PAGE) begin
            rbyte = (state_q == S_PROT) ? prot_q : page_q;
        end else if (idx == `IDX_KHZ_HIGH) begin
            rbyte = khz_high_q;
        end else if (idx == `IDX_KHZ_LOW) begin
            rbyte = khz_low_q;
        end else if (idx == `IDX_DEBUG_CTRL) begin
            rbyte = {7'h00, debug_mode_q};
        end else if (idx == `IDX_ACCESS) begin
            rbyte = {5'h00, wrote_byte_q, page_open_q, timer_busy};
        end else begin
            // unmapped indices read zero
            rbyte = `RESET_BYTE;
        end
    end

    // ----------------------------------------
    // bus response
    // ----------------------------------------
    // ack is registered, so every access costs one wait state
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= req ? {24'h000000, rbyte} : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // kHz bytes load independently; an operation uses whatever pair stands
    always @(posedge clk_i) begin
        if (rst_i) begin
            khz_high_q   <= `RESET_BYTE;
            khz_low_q    <= `RESET_BYTE;
            debug_mode_q <= 1'b0;
        end else begin
            if (wr_dbg) begin
                debug_mode_q <= wbyte[0];
            end
            if (wr && idx == `IDX_KHZ_HIGH) begin
                khz_high_q <= wbyte;
            end
            if (wr && idx == `IDX_KHZ_LOW) begin
                khz_low_q <= wbyte;
            end
        end
    end

    // ----------------------------------------
    // processor stall
    // ----------------------------------------
    // registered from busy or the start strobe, so the cpu idles from the cycle after the launch on
    always @(posedge clk_i) begin
        if (rst_i) begin
            cpu_stall_o <= 1'b0;
        end else begin
            cpu_stall_o <= busy || timer_start_q;
        end
    end

    // ----------------------------------------
    // main sequencer
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q         <= S_LOCKED;
            page_q          <= `RESET_BYTE;
            prot_q          <= `RESET_BYTE;
            page_open_q     <= 1'b0;
            wrote_byte_q    <= 1'b0;
            timer_start_q   <= 1'b0;
            timer_millis_q  <= 1'b0;
            timer_units_q   <= 16'h0000;
            prog_go_o       <= 1'b0;
            page_erase_go_o <= 1'b0;
            mass_erase_go_o <= 1'b0;
            erase_page_o    <= 7'h00;
        end else begin
            timer_start_q   <= 1'b0;
            prog_go_o       <= 1'b0;
            page_erase_go_o <= 1'b0;
            mass_erase_go_o <= 1'b0;

            case (state_q)
                S_LOCKED: begin
                    if (wr_cmd) begin
                        if (wbyte == `CMD_UNLOCK1) begin
                            state_q <= S_FIRST;
                        end else if (wbyte == `CMD_PROT_SELECT) begin
                            state_q <= S_PROT;
                        end
                    end else if (wr_page) begin
                        page_q <= wbyte;
                    end
                end
                S_FIRST: begin
                    if (wr_cmd) begin
                        state_q <= (wbyte == `CMD_UNLOCK2) ? S_SECOND : S_LOCKED;
                    end else if (wr_page) begin
                        page_q <= wbyte;
                    end
                end
                S_SECOND: begin
                    if (wr_cmd) begin
                        state_q <= S_LOCKED;
                    end else if (wr_page) begin
                        // debugger needs no matching rewrite
                        if (debug_mode_q || wbyte == page_q) begin
                            page_q      <= wbyte;
                            page_open_q <= 1'b1;
                            state_q     <= S_UNLOCKED;
                        end else begin
                            state_q <= S_LOCKED;
                        end
                    end else if (debug_mode_q) begin
                        page_open_q <= 1'b1;
                        state_q     <= S_UNLOCKED;
                    end
                end
                S_UNLOCKED: begin
                    // any command closes the page; outside debug mode another page needs a fresh unlock
                    if (wr_cmd) begin
                        page_open_q  <= 1'b0;
                        wrote_byte_q <= 1'b0;
                        state_q      <= S_LOCKED;
                        if (!wrote_byte_q && wbyte == `CMD_PAGE_ERASE && erase_ok) begin
                            erase_page_o    <= page_q[`PAGE_MSB:0];
                            page_erase_go_o <= 1'b1;
                            timer_millis_q  <= 1'b1;
                            timer_units_q   <= `PAGE_ERASE_MS;
                            timer_start_q   <= 1'b1;
                            state_q         <= S_PERASE;
                        end else if (!wrote_byte_q && wbyte == `CMD_MASS_ERASE &&
                                     debug_mode_q && !wp_block) begin
                            mass_erase_go_o <= 1'b1;
                            timer_millis_q  <= 1'b1;
                            timer_units_q   <= `MASS_ERASE_MS;
                            timer_start_q   <= 1'b1;
                            state_q         <= S_MERASE;
                        end
                    end else if (wr_page && debug_mode_q) begin
                        page_q <= wbyte;
                    end else if (prog_req_i && prog_ok) begin
                        wrote_byte_q   <= 1'b1;
                        prog_go_o      <= 1'b1;
                        timer_millis_q <= 1'b0;
                        timer_units_q  <= `PROGRAM_US;
                        timer_start_q  <= 1'b1;
                        state_q        <= S_PROGRAM;
                    end
                end
                S_PROT: begin
                    if (wr_cmd) begin
                        state_q <= (wbyte == `CMD_UNLOCK1) ? S_FIRST : S_LOCKED;
                    end else if (wr_page) begin
                        // user may only add protection
                        prot_q <= debug_mode_q ? wbyte : (prot_q | wbyte);
                    end
                end
                S_PROGRAM: begin
                    // a programmed page stays open for further bytes
                    if (timer_done) begin
                        state_q <= S_UNLOCKED;
                    end
                end
                default: begin
                    if (timer_done) begin
                        state_q <= S_LOCKED;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // address window checks
    // ----------------------------------------
    // reserved region reachable only by code already executing inside it
    wire in_reserved = (prog_addr_i >= `USER_TOP) && (prog_addr_i < `RESERVED_TOP);
    // info mapping follows the select bit even while locked
    wire in_info     = page_q[`INFO_BIT] && (prog_addr_i >= `INFO_BASE);

    always @(posedge clk_i) begin
        if (rst_i) begin
            info_map_o  <= 1'b0;
            access_ok_o <= 1'b0;
        end else begin
            info_map_o  <= in_info;
            access_ok_o <= in_info || (prog_addr_i < `USER_TOP) ||
                           (in_reserved && exec_reserved_i);
        end
    end

endmodule

// File: tb/flash_ctrl_sva.sv
// concurrent checks on the flash controller ports
module flash_ctrl_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [13:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [15:0] prog_addr_i,
    input wire logic        exec_reserved_i,
    input wire logic        prog_go_o,
    input wire logic        page_erase_go_o,
    input wire logic        mass_erase_go_o,
    input wire logic        cpu_stall_o,
    input wire logic        info_map_o,
    input wire logic        access_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic wr_ack = ack_o && we_i;
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_state_rd;
        s_req ##0 (!we_i && adr_i == 14'h3FE0);
    endsequence

    a_ack_on_req: assert property (s_req |=> ack_o) else $error("no ack after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("data without ack");
    a_state_top_zero: assert property (s_state_rd |=> dat_o[31:6] == 26'h0)
        else $error("state reserved bits set");
    a_go_one_hot: assert property ((prog_go_o || page_erase_go_o || mass_erase_go_o)
        |-> $onehot({prog_go_o, page_erase_go_o, mass_erase_go_o})) else $error("go overlap");
    a_erase_stalls: assert property ((page_erase_go_o || mass_erase_go_o)
        |-> ##[0:2] cpu_stall_o) else $error("erase without stall");
    a_program_stalls: assert property (prog_go_o |-> ##[0:2] cpu_stall_o)
        else $error("program without stall");
    a_mass_after_cmd: assert property (mass_erase_go_o
        |-> (wr_ack || $past(wr_ack) || $past(wr_ack, 2))) else $error("mass erase uncommanded");
    a_user_region_ok: assert property ((prog_addr_i < 16'h2000) |=> access_ok_o)
        else $error("user area refused");
    a_reserved_denied: assert property ((prog_addr_i >= 16'h2000 && prog_addr_i < 16'h3000
        && !exec_reserved_i) |=> !access_ok_o) else $error("reserved area allowed");
    a_info_high_only: assert property (info_map_o |-> $past(prog_addr_i) >= 16'hFE00)
        else $error("info map below top");
endmodule

bind flash_ctrl flash_ctrl_sva u_flash_ctrl_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_o, .ack_o, .prog_addr_i, .exec_reserved_i, .prog_go_o, .page_erase_go_o,
    .mass_erase_go_o, .cpu_stall_o, .info_map_o, .access_ok_o);

// File: tb/cpu_host_model.sv
// wishbone master standing in for the cpu or debugger at the register file
module cpu_host_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [13:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // released address and data lines show inverted values so stale data never looks valid
    task automatic xfer(input logic w, input logic [11:0] idx, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'hF;
        dat_o <= {24'h0, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask
endmodule

// File: tb/test_flash_ctrl.sv
// self-checking bench for the flash program/erase controller
module test_flash_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, pgo, ego, mgo, stall, imap, aok;
    logic        wp = 1'b0, preq = 1'b0, xres = 1'b0;
    logic [13:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] paddr = 16'h0000;
    logic [6:0]  epage;
    int          error_cnt = 0, compares = 0, cycles = 0, n_prog = 0, n_pe = 0, n_me = 0;

    always #2.5 clk_i = ~clk_i;

    flash_ctrl u_flash_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .write_protect_i(wp),
        .prog_req_i(preq), .prog_addr_i(paddr), .exec_reserved_i(xres), .prog_go_o(pgo),
        .page_erase_go_o(ego), .mass_erase_go_o(mgo), .erase_page_o(epage),
        .cpu_stall_o(stall), .info_map_o(imap), .access_ok_o(aok));
    cpu_host_model u_cpu_host_model (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // ------------------------------------------------------------
    // go pulse counters and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (pgo === 1'b1) n_prog <= n_prog + 1;
        if (ego === 1'b1) n_pe <= n_pe + 1;
        if (mgo === 1'b1) n_me <= n_me + 1;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        u_cpu_host_model.xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
        u_cpu_host_model.xfer(1'b0, idx, 8'h00, q);
        chk(q, exp);
    endtask
    // low three state bits are don't-care while an operation runs
    task automatic rd_op(input logic [2:0] top);
        u_cpu_host_model.xfer(1'b0, 12'hFF8, 8'h00, q);
        chk(q & 32'hFFFFFFF8, {26'h0, top, 3'h0});
    endtask
    task automatic unlock(input logic [7:0] pg, input logic again);
        wr(12'hFF9, pg);
        wr(12'hFF8, 8'h73);
        wr(12'hFF8, 8'h8C);
        if (again) wr(12'hFF9, pg);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
        while (stall === 1'b1) @(posedge clk_i);
    endtask
    task automatic pulse_prog(input logic [15:0] a);
        @(posedge clk_i);
        paddr <= a;
        preq <= 1'b1;
        @(posedge clk_i);
        preq <= 1'b0;
        settle();
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'hFF8, 32'h0);
        rd(12'hFF9, 32'h0);
        rd(12'hFFA, 32'h0);
        rd(12'h000, 32'h0);
        wr(12'hFFB, 8'h0A);
        rd(12'hFFB, 32'hA);
        wr(12'hFF8, 8'h73);
        rd(12'hFF8, 32'h1);
        wr(12'hFF8, 8'h8C);
        rd(12'hFF8, 32'h2);
        wr(12'hFF9, 8'h00);
        rd(12'hFF8, 32'h3);
        rd(12'hFFD, 32'h2);
        pulse_prog(16'h0020);
        chk(n_prog, 1);
        rd(12'hFFD, 32'h6);
        pulse_prog(16'h0C20);
        chk(n_prog, 1);
        wr(12'hFF8, 8'h95);
        rd(12'hFF8, 32'h0);
        chk(n_pe, 0);
        unlock(8'h05, 1'b1);
        wr(12'hFF8, 8'h95);
        rd_op(3'b010);
        settle();
        rd(12'hFF8, 32'h0);
        chk(n_pe, 1);
        chk(epage, 7'h05);
        wr(12'hFF8, 8'h73);
        wr(12'hFF8, 8'h95);
        rd(12'hFF8, 32'h0);
        unlock(8'h05, 1'b0);
        wr(12'hFF9, 8'h06);
        rd(12'hFF8, 32'h0);
        unlock(8'h05, 1'b1);
        wr(12'hFF8, 8'h63);
        rd(12'hFF8, 32'h0);
        chk(n_me, 0);
        wr(12'hFF8, 8'h00);
        wr(12'hFF8, 8'h5E);
        rd(12'hFF8, 32'h4);
        rd(12'hFF9, 32'h0);
        wr(12'hFF9, 8'h0F);
        rd(12'hFF9, 32'h0F);
        wr(12'hFF9, 8'h00);
        rd(12'hFF9, 32'h0F);
        wr(12'hFF8, 8'h00);
        rd(12'hFF9, 32'h05);
        unlock(8'h05, 1'b1);
        wr(12'hFF8, 8'h95);
        settle();
        chk(n_pe, 1);
        wr(12'hFF8, 8'h00);
        // debugger path until debug control is cleared, with the write-protect option set
        wp <= 1'b1;
        wr(12'hFFC, 8'h01);
        rd(12'hFFC, 32'h1);
        unlock(8'h05, 1'b0);
        rd(12'hFF8, 32'h3);
        wr(12'hFF9, 8'h07);
        rd(12'hFF9, 32'h07);
        wr(12'hFF8, 8'h95);
        settle();
        chk(n_pe, 2);
        chk(epage, 7'h07);
        unlock(8'h05, 1'b0);
        wr(12'hFF8, 8'h63);
        rd_op(3'b100);
        settle();
        rd(12'hFF8, 32'h0);
        chk(n_me, 1);
        unlock(8'h05, 1'b0);
        pulse_prog(16'h1620);
        chk(n_prog, 2);
        wr(12'hFF8, 8'h00);
        wr(12'hFF8, 8'h5E);
        wr(12'hFF9, 8'h00);
        rd(12'hFF9, 32'h0);
        wr(12'hFF8, 8'h00);
        wr(12'hFFC, 8'h00);
        wr(12'hFF9, 8'h80);
        paddr <= 16'hFE10;
        repeat (2) @(posedge clk_i);
        chk(imap, 1'b1);
        paddr <= 16'h2100;
        repeat (2) @(posedge clk_i);
        chk(aok, 1'b0);
        xres <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(aok, 1'b1);
        tally_and_finish();
    end
endmodule
